// ==== core/uls_defines.svh ====
`ifndef ULS_DEFINES_SVH
`define ULS_DEFINES_SVH

`define ULS_OFS_RX_TX_DATA 8'h00
`define ULS_OFS_IRQ_ENABLE 8'h04
`define ULS_OFS_IRQ_SOURCE_CODE 8'h08
`define ULS_OFS_LINE_CTRL 8'h0c
`define ULS_OFS_LINE_STATE_REPORT 8'h14
`define ULS_OFS_DIV_LO 8'h20
`define ULS_OFS_DIV_HI 8'h24

`define ULS_IER_RDA 0
`define ULS_IER_TX_HOLD_EMPTY 1
`define ULS_IER_RLS 2
`define ULS_IER_MS 3

`define ULS_LCR_STB 2
`define ULS_LCR_PEN 3
`define ULS_LCR_EPS 4
`define ULS_LCR_STICK 5
`define ULS_LCR_BREAK 6

`define ULS_IIR_NONE 4'h1
`define ULS_IIR_RLS 4'h6
`define ULS_IIR_RDA 4'h4
`define ULS_IIR_TX_HOLD_EMPTY 4'h2
`define ULS_IIR_MS 4'h0

`define ULS_DIV_RESET 16'h000c
`define ULS_LCR_RESET 8'h03
`define ULS_MID_TICK 4'h7
`define ULS_LAST_TICK 4'hf
`define ULS_HALF_BIT_TICKS 4'h7
`define ULS_STOP1_END 5'h0f
`define ULS_STOP15_END 5'h17
`define ULS_STOP2_END 5'h1f
`endif

// ==== core/uls_pkg.sv ====
package uls_pkg;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } uls_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } uls_apb_rsp_t;

    typedef enum logic [2:0] {
        ULS_RX_IDLE = 3'b000,
        ULS_RX_START = 3'b001,
        ULS_RX_DATA = 3'b010,
        ULS_RX_PAR = 3'b011,
        ULS_RX_STOP = 3'b100,
        ULS_RX_BRK = 3'b101
    } uls_rx_st_t;

    typedef enum logic [2:0] {
        ULS_TX_IDLE = 3'b000,
        ULS_TX_START = 3'b001,
        ULS_TX_DATA = 3'b010,
        ULS_TX_PAR = 3'b011,
        ULS_TX_STOP = 3'b100
    } uls_tx_st_t;

    typedef struct packed {
        uls_apb_rsp_t rsp;
        logic [7:0] snap_lsr;
        logic [3:0] ier;
        logic [7:0] lcr;
        logic [15:0] div;
        logic [15:0] bcnt;
        logic tick;
        uls_rx_st_t rst;
        logic [3:0] rcnt;
        logic [2:0] rbit;
        logic [7:0] rsh;
        logic rpar;
        logic rzero;
        logic [7:0] rbuf;
        logic dr;
        logic oe;
        logic pe;
        logic fe;
        logic bi;
        uls_tx_st_t tst;
        logic [4:0] tcnt;
        logic [2:0] tbit;
        logic [7:0] hold;
        logic hold_empty;
        logic [7:0] tsh;
        logic txo;
        logic tx_hold_empty_irq;
        logic [3:0] irq_source_code;
        logic intr;
        logic sout;
    } uls_state_t;
endpackage : uls_pkg

// ==== core/uls_line_status.sv ====
`timescale 1ns/1ps
`include "uls_defines.svh"
module uls_line_status (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // apb slave
    input wire uls_pkg::uls_apb_req_t i_apb,
    output uls_pkg::uls_apb_rsp_t o_apb,
    // serial line, modem source and interrupt
    input wire logic i_serial_rx_pin,
    input wire logic i_modem_status_pending,
    output logic o_serial_tx,
    output logic o_intr
);
    uls_pkg::uls_state_t s_q;
    uls_pkg::uls_state_t s_d;

    function automatic logic [7:0] char_mask(input logic [1:0] len);
        char_mask = 8'hff >> (2'd3 - len);
    endfunction : char_mask

    function automatic logic [2:0] last_bit(input logic [1:0] len);
        last_bit = {1'b0, len} + 3'd4;
    endfunction : last_bit

    logic setup;
    logic done;
    logic rd_done;
    logic wr_done;
    logic [7:0] addr;
    logic pen;
    logic eps;
    logic stick;
    logic [7:0] rx_char;
    logic rx_ones;
    logic par_bad;
    logic tx_all_idle;
    logic [7:0] lsr_now;
    logic rls_pend;
    logic rda_pend;
    logic tx_hold_empty_pend;
    logic ms_pend;
    logic [3:0] code_now;
    logic [4:0] stop_end;

    always_comb begin
        addr = i_apb.paddr;
        setup = i_apb.psel & ~i_apb.penable;
        done = i_apb.psel & i_apb.penable & s_q.rsp.pready;
        rd_done = done & ~i_apb.pwrite;
        wr_done = done & i_apb.pwrite;
        pen = s_q.lcr[`ULS_LCR_PEN];
        eps = s_q.lcr[`ULS_LCR_EPS];
        stick = s_q.lcr[`ULS_LCR_STICK];
        rx_char = s_q.rsh & char_mask(s_q.lcr[1:0]);
        rx_ones = (^rx_char) ^ s_q.rpar;
        // stick mode fixes the bit; otherwise odd sum expected unless even-select
        par_bad = stick ? (s_q.rpar != ~eps) : (rx_ones == eps);
        tx_all_idle = s_q.hold_empty & (s_q.tst == uls_pkg::ULS_TX_IDLE);
        lsr_now = {1'b0, tx_all_idle, s_q.hold_empty, s_q.bi, s_q.fe, s_q.pe,
                   s_q.oe, s_q.dr};
        // masked sources vanish here, flags keep updating
        rls_pend = s_q.ier[`ULS_IER_RLS] & (s_q.oe | s_q.pe | s_q.fe | s_q.bi);
        rda_pend = s_q.ier[`ULS_IER_RDA] & s_q.dr;
        tx_hold_empty_pend = s_q.ier[`ULS_IER_TX_HOLD_EMPTY] & s_q.tx_hold_empty_irq;
        ms_pend = s_q.ier[`ULS_IER_MS] & i_modem_status_pending;
        if (rls_pend) begin
            code_now = `ULS_IIR_RLS;
        end else if (rda_pend) begin
            code_now = `ULS_IIR_RDA;
        end else if (tx_hold_empty_pend) begin
            code_now = `ULS_IIR_TX_HOLD_EMPTY;
        end else if (ms_pend) begin
            code_now = `ULS_IIR_MS;
        end else begin
            code_now = `ULS_IIR_NONE;
        end
        unique case ({s_q.lcr[`ULS_LCR_STB], s_q.lcr[1:0] == 2'b00})
            2'b10: stop_end = `ULS_STOP2_END;
            2'b11: stop_end = `ULS_STOP15_END;
            default: stop_end = `ULS_STOP1_END;
        endcase
    end

    always_comb begin
        s_d = s_q;

        // apb answer: decode at setup, zero-wait access phase
        s_d.rsp.pready = setup;
        if (setup) begin
            s_d.rsp.pslverr = 1'b0;
            s_d.rsp.prdata = 32'h0000_0000;
            unique case (addr)
                `ULS_OFS_RX_TX_DATA: s_d.rsp.prdata[7:0] = s_q.rbuf;
                `ULS_OFS_IRQ_ENABLE: s_d.rsp.prdata[3:0] = s_q.ier;
                `ULS_OFS_IRQ_SOURCE_CODE: s_d.rsp.prdata[3:0] = s_q.irq_source_code;
                `ULS_OFS_LINE_CTRL: s_d.rsp.prdata[7:0] = s_q.lcr;
                `ULS_OFS_LINE_STATE_REPORT: begin
                    s_d.rsp.prdata[7:0] = lsr_now;
                    s_d.snap_lsr = lsr_now;
                end
                `ULS_OFS_DIV_LO: s_d.rsp.prdata[7:0] = s_q.div[7:0];
                `ULS_OFS_DIV_HI: s_d.rsp.prdata[7:0] = s_q.div[15:8];
                default: s_d.rsp.pslverr = 1'b1;
            endcase
        end

        // read side effects first so that hardware sets below win
        if (rd_done) begin
            if (addr == `ULS_OFS_RX_TX_DATA) begin
                s_d.dr = 1'b0;
            end
            if (addr == `ULS_OFS_LINE_STATE_REPORT) begin
                // only flags that were reported are cleared
                s_d.oe = s_q.oe & ~s_q.snap_lsr[1];
                s_d.pe = s_q.pe & ~s_q.snap_lsr[2];
                s_d.fe = s_q.fe & ~s_q.snap_lsr[3];
                s_d.bi = s_q.bi & ~s_q.snap_lsr[4];
            end
            if (addr == `ULS_OFS_IRQ_SOURCE_CODE && s_q.rsp.prdata[3:0] == `ULS_IIR_TX_HOLD_EMPTY) begin
                s_d.tx_hold_empty_irq = 1'b0;
            end
        end
        if (wr_done) begin
            unique case (addr)
                `ULS_OFS_IRQ_ENABLE: s_d.ier = i_apb.pwdata[3:0];
                `ULS_OFS_LINE_CTRL: s_d.lcr = i_apb.pwdata[7:0];
                `ULS_OFS_DIV_LO: s_d.div[7:0] = i_apb.pwdata[7:0];
                `ULS_OFS_DIV_HI: s_d.div[15:8] = i_apb.pwdata[7:0];
                default: ;
            endcase
        end

        // baud generator: 16x tick, reloaded at once on divisor write
        s_d.tick = 1'b0;
        if (wr_done && (addr == `ULS_OFS_DIV_LO || addr == `ULS_OFS_DIV_HI)) begin
            s_d.bcnt = s_d.div;
        end else if (s_q.bcnt <= 16'h0001) begin
            s_d.bcnt = s_q.div;
            // divisor zero stalls the link rather than running flat out
            s_d.tick = (s_q.div != 16'h0000);
        end else begin
            s_d.bcnt = s_q.bcnt - 16'h0001;
        end

        // receiver
        if (s_q.tick) begin
            s_d.rcnt = s_q.rcnt + 4'h1;
            unique case (s_q.rst)
                uls_pkg::ULS_RX_IDLE: begin
                    s_d.rcnt = 4'h0;
                    if (!i_serial_rx_pin) begin
                        s_d.rst = uls_pkg::ULS_RX_START;
                    end
                end
                uls_pkg::ULS_RX_START: begin
                    if (s_q.rcnt == `ULS_MID_TICK) begin
                        // high at mid start bit is a false start
                        s_d.rst = i_serial_rx_pin ? uls_pkg::ULS_RX_IDLE : uls_pkg::ULS_RX_DATA;
                        s_d.rcnt = 4'h0;
                        s_d.rbit = 3'd0;
                        s_d.rsh = 8'h00;
                        s_d.rzero = 1'b1;
                    end
                end
                uls_pkg::ULS_RX_DATA: begin
                    if (s_q.rcnt == `ULS_LAST_TICK) begin
                        s_d.rsh[s_q.rbit] = i_serial_rx_pin;
                        s_d.rzero = s_q.rzero & ~i_serial_rx_pin;
                        if (s_q.rbit == last_bit(s_q.lcr[1:0])) begin
                            s_d.rst = pen ? uls_pkg::ULS_RX_PAR : uls_pkg::ULS_RX_STOP;
                        end else begin
                            s_d.rbit = s_q.rbit + 3'd1;
                        end
                    end
                end
                uls_pkg::ULS_RX_PAR: begin
                    if (s_q.rcnt == `ULS_LAST_TICK) begin
                        s_d.rpar = i_serial_rx_pin;
                        s_d.rzero = s_q.rzero & ~i_serial_rx_pin;
                        s_d.rst = uls_pkg::ULS_RX_STOP;
                    end
                end
                uls_pkg::ULS_RX_STOP: begin
                    // only the first stop bit is examined
                    if (s_q.rcnt == `ULS_LAST_TICK) begin
                        s_d.rbuf = rx_char;
                        s_d.dr = 1'b1;
                        if (s_q.dr && !(rd_done && addr == `ULS_OFS_RX_TX_DATA)) begin
                            s_d.oe = 1'b1;
                        end
                        if (pen && par_bad) begin
                            s_d.pe = 1'b1;
                        end
                        s_d.rcnt = 4'h0;
                        if (!i_serial_rx_pin) begin
                            s_d.fe = 1'b1;
                            if (s_q.rzero) begin
                                s_d.bi = 1'b1;
                                s_d.rst = uls_pkg::ULS_RX_BRK;
                            end else begin
                                // low stop is the first start sample; second one next tick
                                s_d.rst = uls_pkg::ULS_RX_START;
                                s_d.rcnt = `ULS_MID_TICK;
                            end
                        end else begin
                            s_d.rst = uls_pkg::ULS_RX_IDLE;
                        end
                    end
                end
                uls_pkg::ULS_RX_BRK: begin
                    // needs half a bit of unbroken mark before hunting again
                    if (!i_serial_rx_pin) begin
                        s_d.rcnt = 4'h0;
                    end else if (s_q.rcnt == `ULS_HALF_BIT_TICKS) begin
                        s_d.rst = uls_pkg::ULS_RX_IDLE;
                    end
                end
                default: begin
                    s_d.rst = uls_pkg::ULS_RX_IDLE;
                end
            endcase
        end

        // transmitter
        if (s_q.tst == uls_pkg::ULS_TX_IDLE) begin
            s_d.txo = 1'b1;
            s_d.tcnt = 5'h00;
            if (!s_q.hold_empty) begin
                s_d.tsh = s_q.hold & char_mask(s_q.lcr[1:0]);
                s_d.hold_empty = 1'b1;
                s_d.tx_hold_empty_irq = 1'b1;
                s_d.tst = uls_pkg::ULS_TX_START;
                s_d.txo = 1'b0;
            end
        end else if (s_q.tick) begin
            s_d.tcnt = s_q.tcnt + 5'h01;
            unique case (s_q.tst)
                uls_pkg::ULS_TX_START: begin
                    if (s_q.tcnt == {1'b0, `ULS_LAST_TICK}) begin
                        s_d.tcnt = 5'h00;
                        s_d.tbit = 3'd0;
                        s_d.txo = s_q.tsh[0];
                        s_d.tst = uls_pkg::ULS_TX_DATA;
                    end
                end
                uls_pkg::ULS_TX_DATA: begin
                    if (s_q.tcnt == {1'b0, `ULS_LAST_TICK}) begin
                        s_d.tcnt = 5'h00;
                        if (s_q.tbit == last_bit(s_q.lcr[1:0])) begin
                            s_d.tst = pen ? uls_pkg::ULS_TX_PAR : uls_pkg::ULS_TX_STOP;
                            s_d.txo = stick ? ~eps : (^s_q.tsh) ^ ~eps;
                            if (!pen) begin
                                s_d.txo = 1'b1;
                            end
                        end else begin
                            s_d.tbit = s_q.tbit + 3'd1;
                            s_d.txo = s_q.tsh[s_q.tbit + 3'd1];
                        end
                    end
                end
                uls_pkg::ULS_TX_PAR: begin
                    if (s_q.tcnt == {1'b0, `ULS_LAST_TICK}) begin
                        s_d.tcnt = 5'h00;
                        s_d.txo = 1'b1;
                        s_d.tst = uls_pkg::ULS_TX_STOP;
                    end
                end
                uls_pkg::ULS_TX_STOP: begin
                    if (s_q.tcnt == stop_end) begin
                        s_d.tst = uls_pkg::ULS_TX_IDLE;
                    end
                end
                default: begin
                    s_d.tst = uls_pkg::ULS_TX_IDLE;
                end
            endcase
        end

        // a fresh holding write really fills the buffer, so it beats the move
        if (wr_done && addr == `ULS_OFS_RX_TX_DATA) begin
            s_d.hold = i_apb.pwdata[7:0];
            s_d.hold_empty = 1'b0;
            s_d.tx_hold_empty_irq = 1'b0;
        end

        // identification held still while the host is addressing it
        if (!(i_apb.psel && addr == `ULS_OFS_IRQ_SOURCE_CODE)) begin
            s_d.irq_source_code = code_now;
        end
        s_d.intr = (code_now != `ULS_IIR_NONE);
        // break only forces the pin; the shifter keeps its timing
        s_d.sout = s_d.txo & ~s_d.lcr[`ULS_LCR_BREAK];
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s_q <= '0;
            s_q.lcr <= `ULS_LCR_RESET;
            s_q.div <= `ULS_DIV_RESET;
            s_q.bcnt <= `ULS_DIV_RESET;
            s_q.rst <= uls_pkg::ULS_RX_IDLE;
            s_q.tst <= uls_pkg::ULS_TX_IDLE;
            s_q.hold_empty <= 1'b1;
            s_q.txo <= 1'b1;
            s_q.sout <= 1'b1;
            s_q.irq_source_code <= `ULS_IIR_NONE;
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        o_apb = s_q.rsp;
        o_intr = s_q.intr;
        o_serial_tx = s_q.sout;
    end
endmodule : uls_line_status

// ==== testbench/uls_line_status_chk.sv ====
`timescale 1ns/1ps
`include "uls_defines.svh"
module uls_line_status_chk (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // watched ports
    input wire uls_pkg::uls_apb_req_t i_apb,
    input wire uls_pkg::uls_apb_rsp_t o_apb,
    input wire logic i_serial_rx_pin,
    input wire logic i_modem_status_pending,
    input wire logic o_serial_tx,
    input wire logic o_intr
);
    localparam logic [7:0] st_a = `ULS_OFS_LINE_STATE_REPORT;
    localparam logic [7:0] id_a = `ULS_OFS_IRQ_SOURCE_CODE;
    localparam logic [7:0] dt_a = `ULS_OFS_RX_TX_DATA;
    logic [3:0] ier_q;
    logic acc;
    assign acc = i_apb.psel && i_apb.penable && o_apb.pready;
    // shadow of the enables, rebuilt from completed writes
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ier_q <= 4'h0;
        end else if (acc && i_apb.pwrite && i_apb.paddr == `ULS_OFS_IRQ_ENABLE) begin
            ier_q <= i_apb.pwdata[3:0];
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    sequence s_rd(logic [7:0] a);
        acc && !i_apb.pwrite && i_apb.paddr == a;
    endsequence
    sequence s_err_rd;
        s_rd(st_a) and (o_apb.prdata[4:1] != 4'h0);
    endsequence
    a_status_top_zero: assert property (s_rd(st_a) |-> o_apb.prdata[31:7] == 25'h0)
        else $error("status upper bits set");
    a_code_legal: assert property (s_rd(id_a) |-> o_apb.prdata[31:3] == 29'h0 &&
        o_apb.prdata[2:0] inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h6})
        else $error("illegal source code");
    a_empty_order: assert property ((s_rd(st_a) and o_apb.prdata[6]) |-> o_apb.prdata[5])
        else $error("all idle without holding empty");
    a_masked_quiet: assert property (ier_q == 4'h0 && $past(ier_q) == 4'h0 |-> !o_intr)
        else $error("interrupt with all sources masked");
    a_none_masked: assert property ((s_rd(id_a) and (ier_q == 4'h0 &&
        $past(ier_q, 3) == 4'h0)) |-> o_apb.prdata[3:0] == 4'h1)
        else $error("code shows a masked source");
    a_status_clears: assert property (s_err_rd ##[1:4] s_rd(st_a) |->
        o_apb.prdata[4:1] == 4'h0)
        else $error("error flags survive a status read");
    a_ready_clears: assert property (s_rd(dt_a) ##[1:4] s_rd(st_a) |-> !o_apb.prdata[0])
        else $error("data ready survives a buffer read");
    a_status_irq: assert property ((s_err_rd and ier_q[2]) |=> o_intr)
        else $error("no interrupt for a line error");
endmodule : uls_line_status_chk

bind uls_line_status uls_line_status_chk uls_line_status_chk_inst (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_apb(i_apb),
    .o_apb(o_apb),
    .i_serial_rx_pin(i_serial_rx_pin),
    .i_modem_status_pending(i_modem_status_pending),
    .o_serial_tx(o_serial_tx),
    .o_intr(o_intr)
);

// ==== testbench/uls_serial_src.sv ====
`timescale 1ns/1ps
module uls_serial_src #(
    parameter int BIT_CLKS = 192
) (
    // clock
    input wire logic i_ref_clk,
    // line toward the receiver, idle high
    output logic o_line
);
    initial o_line = 1'b1;
    task automatic put_bit(input logic v);
        o_line <= v;
        repeat (BIT_CLKS) @(posedge i_ref_clk);
    endtask : put_bit
    // without lead the frame continues straight into data bits
    task automatic send_frame(input logic [7:0] d, input logic lead, input logic pen,
        input logic par, input logic stop);
        if (lead) begin
            put_bit(1'b1);
            put_bit(1'b0);
        end
        for (int i = 0; i < 8; i++) begin
            put_bit(d[i]);
        end
        if (pen) begin
            put_bit(par);
        end
        put_bit(stop);
    endtask : send_frame
    task automatic send_break(input int bits);
        repeat (bits) put_bit(1'b0);
        put_bit(1'b1);
    endtask : send_break
endmodule : uls_serial_src

// ==== testbench/test_uart_line_status_and_irq_id.sv ====
`timescale 1ns/1ps
`include "uls_defines.svh"
module test_uart_line_status_and_irq_id;
    // divisor kept at reset value; line rate is scaled for simulation only
    localparam int BIT_CLKS = 16 * 12;
    localparam logic [7:0] st_a = `ULS_OFS_LINE_STATE_REPORT;
    localparam logic [7:0] id_a = `ULS_OFS_IRQ_SOURCE_CODE;
    localparam logic [7:0] dt_a = `ULS_OFS_RX_TX_DATA;
    localparam logic [7:0] ie_a = `ULS_OFS_IRQ_ENABLE;
    localparam logic [7:0] lc_a = `ULS_OFS_LINE_CTRL;
    logic i_ref_clk;
    logic i_rst_b;
    uls_pkg::uls_apb_req_t i_apb;
    uls_pkg::uls_apb_rsp_t o_apb;
    logic serial_rx;
    logic modem_pend;
    logic serial_tx;
    logic intr;
    logic tx_low_seen = 1'b0;
    logic [31:0] rd;
    logic err;
    int failures = 0;
    int checks = 0;

    uls_line_status uls_line_status_inst (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_apb(i_apb),
        .o_apb(o_apb),
        .i_serial_rx_pin(serial_rx),
        .i_modem_status_pending(modem_pend),
        .o_serial_tx(serial_tx),
        .o_intr(intr)
    );
    uls_serial_src #(.BIT_CLKS(BIT_CLKS)) uls_serial_src_inst (
        .i_ref_clk(i_ref_clk),
        .o_line(serial_rx)
    );

    initial begin
        i_ref_clk = 1'b0;
        forever #4 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk) begin
        if (serial_tx === 1'b0) begin
            tx_low_seen <= 1'b1;
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict

    // request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge i_ref_clk);
        i_apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge i_ref_clk);
        i_apb.penable <= 1'b1;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (o_apb.pready !== 1'b1 && n < 16);
        rd = o_apb.prdata;
        err = o_apb.pslverr;
        i_apb.psel <= 1'b0;
        i_apb.penable <= 1'b0;
        if (o_apb.pready !== 1'b1) begin
            failures++;
            give_verdict();
        end
    endtask : apb

    task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        check(what, exp, rd);
    endtask : expect_reg

    task automatic t_reset();
        expect_reg(st_a, 32'h60, "status");
        expect_reg(id_a, 32'h1, "code");
        apb(1'b1, st_a, 32'hff);
        expect_reg(st_a, 32'h60, "status after write");
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped error", 32'h1, {31'h0, err});
        $display("test reset done");
    endtask : t_reset

    task automatic t_rx();
        apb(1'b1, ie_a, 32'h5);
        uls_serial_src_inst.send_frame(8'ha5, 1'b1, 1'b0, 1'b0, 1'b1);
        check("intr", 32'h1, {31'h0, intr});
        expect_reg(id_a, 32'h4, "code");
        expect_reg(st_a, 32'h61, "status");
        expect_reg(dt_a, 32'ha5, "rx data");
        expect_reg(st_a, 32'h60, "status");
        expect_reg(id_a, 32'h1, "code");
        $display("test rx done");
    endtask : t_rx

    task automatic t_overrun();
        uls_serial_src_inst.send_frame(8'h11, 1'b1, 1'b0, 1'b0, 1'b1);
        uls_serial_src_inst.send_frame(8'h22, 1'b1, 1'b0, 1'b0, 1'b1);
        expect_reg(id_a, 32'h6, "code");
        expect_reg(st_a, 32'h63, "status");
        expect_reg(st_a, 32'h61, "status");
        expect_reg(id_a, 32'h4, "code");
        expect_reg(dt_a, 32'h22, "rx data");
        $display("test overrun done");
    endtask : t_overrun

    task automatic t_parity();
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, lc_a, (i == 1) ? 32'h1b : 32'h0b);
            uls_serial_src_inst.send_frame(8'h01, 1'b1, 1'b1, 1'b0, 1'b1);
            expect_reg(st_a, (i == 1) ? 32'h65 : 32'h61, "status");
            expect_reg(dt_a, 32'h01, "rx data");
        end
        apb(1'b1, lc_a, 32'h03);
        $display("test parity done");
    endtask : t_parity

    task automatic t_framing();
        uls_serial_src_inst.send_frame(8'h55, 1'b1, 1'b0, 1'b0, 1'b0);
        uls_serial_src_inst.send_frame(8'hff, 1'b0, 1'b0, 1'b0, 1'b1);
        expect_reg(st_a, 32'h6b, "status");
        expect_reg(dt_a, 32'hff, "rx data");
        expect_reg(st_a, 32'h60, "status");
        $display("test framing done");
    endtask : t_framing

    task automatic t_break();
        uls_serial_src_inst.send_break(12);
        expect_reg(st_a, 32'h79, "status");
        expect_reg(dt_a, 32'h00, "rx data");
        uls_serial_src_inst.send_frame(8'h3c, 1'b1, 1'b0, 1'b0, 1'b1);
        expect_reg(st_a, 32'h61, "status");
        expect_reg(dt_a, 32'h3c, "rx data");
        $display("test break done");
    endtask : t_break

    task automatic t_tx();
        int n;
        n = 0;
        modem_pend <= 1'b1;
        apb(1'b1, ie_a, 32'ha);
        apb(1'b1, dt_a, 32'h81);
        apb(1'b1, dt_a, 32'h7e);
        expect_reg(st_a, 32'h00, "status while sending");
        do begin
            apb(1'b0, st_a, 32'h0);
            n++;
        end while (rd !== 32'h60 && n < 2000);
        check("status after sending", 32'h60, rd);
        if (rd !== 32'h60) begin
            give_verdict();
        end
        check("tx start seen", 32'h1, {31'h0, tx_low_seen});
        check("intr", 32'h1, {31'h0, intr});
        expect_reg(id_a, 32'h2, "code");
        expect_reg(id_a, 32'h0, "code");
        apb(1'b1, ie_a, 32'h0);
        expect_reg(id_a, 32'h1, "code");
        check("intr masked", 32'h0, {31'h0, intr});
        modem_pend <= 1'b0;
        $display("test tx done");
    endtask : t_tx

    initial begin
        i_rst_b = 1'b0;
        i_apb = '0;
        modem_pend = 1'b0;
        repeat (3) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        t_reset();
        t_rx();
        t_overrun();
        t_parity();
        t_framing();
        t_break();
        t_tx();
        give_verdict();
    end
endmodule : test_uart_line_status_and_irq_id
